/* dv/pwm_load.sv */
`timescale 1ns/1ps
// ==========================================================================
// Load on one channel pin
// No pull on the pin, so a released pin shows the inverse of its last level
module pwm_load (
  input  wire logic clk_sys,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      level
);
  logic last_q = 1'b0;
  always_ff @(posedge clk_sys) begin
    if (pin_oe) last_q <= pin_o;
  end
  assign level = pin_oe ? pin_o : ~last_q;
endmodule : pwm_load

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk_sys, reset_n, awvalid, wvalid, bready, arvalid, rready, l0, l1;
  logic        awready, wready, bvalid, arready, rvalid, chan0_gate_input, chan1_gate_input;
  logic        chan0_pin_o, chan0_pin_oe, chan1_pin_o, chan1_pin_oe;
  logic        chan0_overflow, chan1_overflow;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  d, h;
  int          errors, compares, cyc, t, s, hi, per, ov, c0;

  timer_pwm_output_unit DUT (.clk_sys, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .chan0_gate_input, .chan1_gate_input, .chan0_pin_o, .chan0_pin_oe,
    .chan1_pin_o, .chan1_pin_oe, .chan0_overflow, .chan1_overflow);
  pwm_load load0 (.clk_sys, .pin_o(chan0_pin_o), .pin_oe(chan0_pin_oe), .level(l0));
  pwm_load load1 (.clk_sys, .pin_o(chan1_pin_o), .pin_oe(chan1_pin_oe), .level(l1));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Checking and closing
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // Whole run needs about 25k cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Bus master
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    bit pa = 1'b1;
    bit pw = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    {awvalid, wvalid, bready} <= 3'b111;
    while (pa | pw) begin
      @(posedge clk_sys);
      if (awready === 1'b1) pa = 1'b0;
      if (wready === 1'b1) pw = 1'b0;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd_reg(input logic [11:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd_reg

  // ==========================================================================
  // Pin measure: high time, period and overflow pulses from one rise to the next
  task automatic meas(input bit ch, input int lim);
    int   k = 0;
    int   ph = 0;
    logic pv, cv;
    hi = 1;
    per = 0;
    ov = 0;
    pv = ch ? l1 : l0;
    while (ph < 3 && k < lim) begin
      @(posedge clk_sys);
      k++;
      cv = ch ? l1 : l0;
      if (ph > 0) begin
        per++;
        ov += ch ? chan1_overflow : chan0_overflow;
        if (ph == 1 && cv) hi++;
      end
      if (!pv && cv) ph = (ph == 0) ? 1 : 3;
      else if (pv && !cv && ph == 1) ph = 2;
      pv = cv;
    end
    if (ph < 3) per = 0;
  endtask : meas

  // ==========================================================================
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, reset_n} = '0;
    {chan0_gate_input, chan1_gate_input} = 2'b11;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(98));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wr(12'h645, 8'hff);
    chk("alias bresp", 32'(rs), 32'h2);
    rd_reg(12'h244);
    chk("prescale_ctrl", rd, 32'h24);
    rd_reg(12'h000);
    chk("unmapped rresp", 32'(rs), 32'h2);
    wr(12'h3fc, 8'h5a);
    chk("unmapped bresp", 32'(rs), 32'h2);
    for (int i = 0; i < 2; i++) begin
      t = $urandom_range(1, 0);
      d = 8'($urandom_range(255, 1));
      s = (2 << i) * (t + 1);
      wr(12'h208, 8'(t));
      wr(12'h21c, d);
      wr(12'h204, 8'h00);
      wr(12'h244, 8'h40 | 8'(i));
      wr(12'h200, 8'h01);
      meas(0, 6000);
      chk("m0 high", hi, d * s);
      chk("m0 period", per, 256 * s);
      chk("m0 overflow", ov, 1);
    end
    h = 8'hfc | 8'($urandom_range(3, 0));
    d = 8'($urandom_range(255, 64));
    s = (256 - h) * (t + 1);
    wr(12'h218, h);
    wr(12'h21c, d);
    wr(12'h204, 8'h01);
    meas(0, 6000);
    chk("m1 period", per, 256 * s);
    c0 = cyc;
    wr(12'h21c, d ^ 8'h20);
    while (l0) @(posedge clk_sys);
    chk("m1 held duty", cyc - c0, d * s);
    meas(0, 6000);
    chk("m1 new duty", hi, (d ^ 8'h20) * s);
    wr(12'h21c, 8'h00);
    meas(0, 768 * s);
    chk("zero duty", per, 0);
    chk("zero duty level", 32'(l0), 32'h0);
    t = $urandom_range(3, 0);
    h = 8'($urandom_range(255, 192));
    s = (256 - h) * (t + 1);
    wr(12'h208, 8'(t));
    wr(12'h224, h);
    wr(12'h228, 8'h3c);
    wr(12'h22c, 8'hc3);
    wr(12'h204, 8'h20);
    wr(12'h244, 8'h80);
    wr(12'h200, 8'h02);
    meas(1, 2000);
    chk("m2 half", hi, s);
    chk("m2 period", per, 2 * s);
    chk("m2 overflow", ov, 2);
    rd_reg(12'h228);
    chk("scratch reload", rd, 32'h3c);
    rd_reg(12'h22c);
    chk("scratch duty", rd, 32'hc3);
    rd_reg(12'h200);
    chk("flags", rd, 32'h32);
    wr(12'h200, 8'h12);
    rd_reg(12'h200);
    chk("flag clear", rd, 32'h22);
    chk("enables", 32'({chan1_pin_oe, chan0_pin_oe}), 32'h2);
    chan1_gate_input <= 1'b0;
    wr(12'h204, 8'ha0);
    meas(1, 1000);
    chk("gate held", per, 0);
    chan1_gate_input <= 1'b1;
    meas(1, 2000);
    chk("gate open", per, 2 * s);
    wr(12'h204, 8'h30);
    meas(1, 1000);
    chk("split hold", per, 0);
    wr(12'h244, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("released", 32'({chan1_pin_oe, chan0_pin_oe}), 32'h0);
    tally_and_finish();
  end
endmodule : testbench

/* src/pwm_channel.sv */
`timescale 1ns/1ps

module pwm_channel (
  input  logic               clk_sys,
  input  logic               reset_n,
  input  logic               tick,
  input  logic               run,
  input  pwm_pkg::wave_mode_e mode,
  input  logic [2:0]         psc,
  input  logic [7:0]         low_reload,
  input  logic [7:0]         duty,
  input  logic               wr_low,
  input  logic               wr_high,
  input  logic [7:0]         wdata,
  output logic [7:0]         low_q,
  output logic [7:0]         high_q,
  output logic               wave_q,
  output logic               ovf_q
);

  logic [7:0] lmask;
  logic [7:0] shadow_q;
  logic       lstep;
  logic       low_full;
  logic       hstep;
  logic       high_roll;
  logic       pwm_mode;

  // ==========================================================================
  // Step conditions
  always_comb begin
    lmask     = 8'hff >> (3'h7 - psc);
    pwm_mode  = (mode == pwm_pkg::MODE_LOG) || (mode == pwm_pkg::MODE_LIN);
    lstep     = tick && run && (mode != pwm_pkg::MODE_SPLIT);
    low_full  = (mode == pwm_pkg::MODE_LOG) ? ((low_q & lmask) == lmask) : (low_q == 8'hff);
    hstep     = lstep && low_full && pwm_mode;
    high_roll = hstep && (high_q == 8'hff);
  end

  // ==========================================================================
  // Counters
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= 8'h00;
    end else if (wr_low) begin
      low_q <= wdata;
    end else if (lstep) begin
      if (!low_full) begin
        low_q <= 8'(low_q + 8'h01);
      end else begin
        case (mode)
          pwm_pkg::MODE_LOG:  low_q <= low_q & ~lmask;
          pwm_pkg::MODE_LIN:  low_q <= low_reload;
          pwm_pkg::MODE_FREQ: low_q <= high_q;
          default:            low_q <= low_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      high_q <= 8'h00;
    end else if (wr_high) begin
      high_q <= wdata;
    end else if (hstep) begin
      high_q <= 8'(high_q + 8'h01);
    end
  end

  // ==========================================================================
  // Waveform; shadow only moves at rollover so a duty write never glitches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shadow_q <= 8'h00;
      wave_q   <= 1'b0;
      ovf_q    <= 1'b0;
    end else begin
      ovf_q <= high_roll || (mode == pwm_pkg::MODE_FREQ && lstep && low_full);
      if (high_roll) begin
        shadow_q <= duty;
        wave_q   <= (duty != 8'h00);
      end else if (hstep && 8'(high_q + 8'h01) == shadow_q) begin
        wave_q   <= 1'b0;
      end else if (mode == pwm_pkg::MODE_FREQ && lstep && low_full) begin
        wave_q   <= ~wave_q;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_roll;
    hstep && high_q == 8'hff;
  endsequence

  AST_ROLL_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    seq_roll |=> (shadow_q == $past(duty)) && (high_q == 8'h00 || $past(wr_high)))
    else $error("Shadow compare not loaded at rollover");
  AST_DUTY_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (seq_roll and duty == 8'h00) |=> !wave_q)
    else $error("Zero duty did not keep output low");
  AST_MATCH_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (hstep && high_q != 8'hff && 8'(high_q + 8'h01) == shadow_q) |=> !wave_q)
    else $error("Output not cleared at compare match");
  AST_TOGGLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode == pwm_pkg::MODE_FREQ && lstep && low_full) |=> wave_q != $past(wave_q))
    else $error("Square wave did not toggle on overflow");
  AST_LIN_RELOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode == pwm_pkg::MODE_LIN && lstep && low_full && !wr_low) |=> low_q == $past(low_reload))
    else $error("Linear prescaler not reloaded");
  AST_SPLIT_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode == pwm_pkg::MODE_SPLIT && !wr_low && !wr_high) |=> $stable(low_q) && $stable(high_q))
    else $error("Counters moved in hold mode");

endmodule : pwm_channel

/* src/pwm_pkg.sv */
package pwm_pkg;

  typedef enum logic [1:0] {
    MODE_LOG   = 2'h0,
    MODE_LIN   = 2'h1,
    MODE_FREQ  = 2'h2,
    MODE_SPLIT = 2'h3
  } wave_mode_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_e;

endpackage : pwm_pkg

/* src/pwm_regs.svh */
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// ==========================================================================
// Bus geometry
`define ADDR_W            12
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ==========================================================================
// Register indices; byte address is four times the index
`define IDX_RUN_FLAGS     8'h80
`define IDX_TIMER_MODE    8'h81
`define IDX_GLOBAL_PSC    8'h82
`define IDX_CH0_LOW       8'h84
`define IDX_CH0_HIGH      8'h85
`define IDX_CH0_RELOAD    8'h86
`define IDX_CH0_DUTY      8'h87
`define IDX_CH_STRIDE     8'h04
`define IDX_PRESCALE_CTRL 8'h91

// ==========================================================================
// Field positions
`define BIT_CH1_EN        7
`define BIT_CH0_EN        6
`define CHAN1_LOG_PRESCALE_LSB          3
`define CHAN0_LOG_PRESCALE_LSB          0
`define RUN_LSB           0
`define FLAG_LSB          4
`define MODE1_LSB         4
`define MODE0_LSB         0
`define GATE1_BIT         7
`define GATE0_BIT         3

// ==========================================================================
// Reset values
`define RST_PRESCALE_CTRL 8'h24
`define RST_BYTE          8'h00
`define RST_TPS           4'h0

`endif

/* src/timer_pwm_output_unit.sv */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "pwm_regs.svh"

// ==========================================================================
// Function
// - Enable bit 7 drives channel 1 wave on its pin; bit 6 channel 0.
// - Log prescale field gives active low-counter bits of value plus one; resets to 100B.
// - Both timers are independently usable as 8-bit edge-aligned wave generators.
// - Overflow flags and the overflow pulse for baud timing keep working.
// - External gate input can halt the timer and hence the waveform.
// - Each channel has four modes from its 2-bit timer mode field.
// - Output rises at high counter 00H, falls when it reaches the compare value.
// - New duty takes effect only at the FFH to 00H rollover.
// - Duty value 00H keeps the output low.
// - Mode 0 uses the low counter as logarithmic prescaler for the high counter.
// - Modes 0 and 1 load the shadow compare at rollover and set output high unless duty is 00H.
// - Mode 1 low counter reloads from low reload on every overflow.
// - Mode 2 is 8-bit auto-reload; pin toggles on each low overflow.
// - Mode 2 period is 256 minus high reload, doubled by the toggle.
// - Channel 1 behaves like channel 0 using its own registers and pin.
// - Mode 2 leaves duty and low reload registers free for scratch use.
// - With gate set, count only while gate pin high and run set.
// - Channel mode 3 holds the count as if run were clear.
module timer_pwm_output_unit (
  input  logic               clk_sys,
  input  logic               reset_n,
  input  logic [`ADDR_W-1:0] awaddr,
  input  logic               awvalid,
  output logic               awready,
  input  logic [31:0]        wdata,
  input  logic [3:0]         wstrb,
  input  logic               wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  logic               bready,
  input  logic [`ADDR_W-1:0] araddr,
  input  logic               arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  logic               rready,
  input  logic               chan0_gate_input,
  input  logic               chan1_gate_input,
  output logic               chan0_pin_o,
  output logic               chan0_pin_oe,
  output logic               chan1_pin_o,
  output logic               chan1_pin_oe,
  output logic               chan0_overflow,
  output logic               chan1_overflow
);

  // ==========================================================================
  // Address decode, shared by the read and write paths
  function automatic logic [7:0] addr_idx(input logic [`ADDR_W-1:0] a);
    addr_idx = a[9:2];
  endfunction : addr_idx

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    addr_hit = (a[1:0] == 2'h0) && (a[`ADDR_W-1:10] == '0) &&
               ((i == `IDX_RUN_FLAGS) || (i == `IDX_TIMER_MODE) ||
                (i == `IDX_GLOBAL_PSC) || (i == `IDX_PRESCALE_CTRL) ||
                (i >= `IDX_CH0_LOW && i < 8'(`IDX_CH0_LOW + 2 * `IDX_CH_STRIDE)));
  endfunction : addr_hit

  // ==========================================================================
  // State
  pwm_pkg::wr_state_e wr_state_q;
  logic               awready_q;
  logic               wready_q;
  logic               aw_held_q;
  logic               w_held_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic [`ADDR_W-1:0] aw_addr_q;
  logic [7:0]         wbyte_q;
  logic               wlane_q;
  logic               arready_q;
  logic               rvalid_q;
  logic [1:0]         rresp_q;
  logic [31:0]        rdata_q;
  logic               wr_fire;
  logic [7:0]         wr_idx;

  logic [7:0]         ctrl_q;
  logic [7:0]         tmode_q;
  logic [1:0]         run_q;
  logic [1:0]         flag_q;
  logic [3:0]         tps_q;
  logic [3:0]         tps_cnt_q;
  logic               tick;
  logic [1:0]         gate_meta_q;
  logic [1:0]         gate_sync_q;
  logic [1:0]         pin_o_q;
  logic [1:0]         pin_oe_q;
  logic [1:0]         ovf_out_q;
  logic [7:0]         rd_mux;

  logic [7:0]         duty_q   [2];
  logic [7:0]         reload_q [2];
  logic [7:0]         low_cnt  [2];
  logic [7:0]         high_cnt [2];
  logic [1:0]         wave;
  logic [1:0]         ovf;
  logic [1:0]         en;
  logic [1:0]         run_eff;
  logic [1:0]         wr_low;
  logic [1:0]         wr_high;

  assign awready        = awready_q;
  assign wready         = wready_q;
  assign bvalid         = bvalid_q;
  assign bresp          = bresp_q;
  assign arready        = arready_q;
  assign rvalid         = rvalid_q;
  assign rresp          = rresp_q;
  assign rdata          = rdata_q;
  assign chan0_pin_o    = pin_o_q[0];
  assign chan0_pin_oe   = pin_oe_q[0];
  assign chan1_pin_o    = pin_o_q[1];
  assign chan1_pin_oe   = pin_oe_q[1];
  assign chan0_overflow = ovf_out_q[0];
  assign chan1_overflow = ovf_out_q[1];

  assign en      = {ctrl_q[`BIT_CH1_EN], ctrl_q[`BIT_CH0_EN]};
  assign wr_fire = (wr_state_q == pwm_pkg::WR_IDLE) && aw_held_q && w_held_q;
  // Unmapped or misaligned writes answer SLVERR and must not alias onto a register
  assign wr_idx  = addr_hit(aw_addr_q) ? addr_idx(aw_addr_q) : 8'h00;

  // ==========================================================================
  // AXI4-Lite write path; address and data may arrive in either order
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_state_q <= pwm_pkg::WR_IDLE;
      awready_q  <= 1'b1;
      wready_q   <= 1'b1;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
      aw_addr_q  <= '0;
      wbyte_q    <= 8'h00;
      wlane_q    <= 1'b0;
    end else begin
      case (wr_state_q)
        pwm_pkg::WR_IDLE: begin
          if (awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= awaddr;
          end
          if (wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wbyte_q  <= wdata[7:0];
            wlane_q  <= wstrb[0];
          end
          if (wr_fire) begin
            bvalid_q   <= 1'b1;
            bresp_q    <= addr_hit(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
            wr_state_q <= pwm_pkg::WR_RESP;
          end
        end
        pwm_pkg::WR_RESP: begin
          if (bready) begin
            bvalid_q   <= 1'b0;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            wr_state_q <= pwm_pkg::WR_IDLE;
          end
        end
        default: wr_state_q <= pwm_pkg::WR_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read path; one cycle from address handshake to data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= addr_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q   <= {24'h00_0000, addr_hit(araddr) ? rd_mux : 8'h00};
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (addr_idx(araddr))
      `IDX_RUN_FLAGS:     rd_mux = {2'h0, flag_q, 2'h0, run_q};
      `IDX_TIMER_MODE:    rd_mux = tmode_q;
      `IDX_GLOBAL_PSC:    rd_mux = {4'h0, tps_q};
      `IDX_PRESCALE_CTRL: rd_mux = ctrl_q;
      8'h84:              rd_mux = low_cnt[0];
      8'h85:              rd_mux = high_cnt[0];
      8'h86:              rd_mux = reload_q[0];
      8'h87:              rd_mux = duty_q[0];
      8'h88:              rd_mux = low_cnt[1];
      8'h89:              rd_mux = high_cnt[1];
      8'h8a:              rd_mux = reload_q[1];
      8'h8b:              rd_mux = duty_q[1];
      default:            rd_mux = 8'h00;
    endcase
  end

  // ==========================================================================
  // Shared control registers; only byte lane 0 carries data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q  <= `RST_PRESCALE_CTRL;
      tmode_q <= `RST_BYTE;
      tps_q   <= `RST_TPS;
      run_q   <= 2'h0;
    end else if (wr_fire && wlane_q) begin
      case (wr_idx)
        `IDX_PRESCALE_CTRL: ctrl_q  <= wbyte_q;
        `IDX_TIMER_MODE:    tmode_q <= wbyte_q;
        `IDX_GLOBAL_PSC:    tps_q   <= wbyte_q[3:0];
        `IDX_RUN_FLAGS:     run_q   <= wbyte_q[`RUN_LSB +: 2];
        default:            ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // Overflow flags are write-one-to-clear, and a new overflow beats the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (ovf[k]) begin
          flag_q[k] <= 1'b1;
        end else if (wr_fire && wlane_q && wr_idx == `IDX_RUN_FLAGS &&
                     wbyte_q[`FLAG_LSB + k]) begin
          flag_q[k] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Global prescale: every timer steps once per tps_q + 1 clocks
  assign tick = (tps_cnt_q == tps_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tps_cnt_q <= 4'h0;
    end else if (tick) begin
      tps_cnt_q <= 4'h0;
    end else begin
      tps_cnt_q <= 4'(tps_cnt_q + 4'h1);
    end
  end

  // Gate pins are asynchronous, so two flops before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gate_meta_q <= 2'h0;
      gate_sync_q <= 2'h0;
    end else begin
      gate_meta_q <= {chan1_gate_input, chan0_gate_input};
      gate_sync_q <= gate_meta_q;
    end
  end

  // ==========================================================================
  // Channels
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    localparam logic [7:0] BASE = 8'(`IDX_CH0_LOW + g * `IDX_CH_STRIDE);

    logic                gate_bit;
    logic [2:0]          psc;
    pwm_pkg::wave_mode_e mode;

    assign gate_bit   = tmode_q[g ? `GATE1_BIT : `GATE0_BIT];
    assign psc        = ctrl_q[(g ? `CHAN1_LOG_PRESCALE_LSB : `CHAN0_LOG_PRESCALE_LSB) +: 3];
    assign mode       = pwm_pkg::wave_mode_e'(tmode_q[(g ? `MODE1_LSB : `MODE0_LSB) +: 2]);
    assign run_eff[g] = run_q[g] && (!gate_bit || gate_sync_q[g]);
    assign wr_low[g]  = wr_fire && wlane_q && (wr_idx == BASE);
    assign wr_high[g] = wr_fire && wlane_q && (wr_idx == 8'(BASE + 8'h01));

    // Reload and duty stay plain storage, so mode 2 leaves them free
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        reload_q[g] <= `RST_BYTE;
        duty_q[g]   <= `RST_BYTE;
      end else if (wr_fire && wlane_q) begin
        if (wr_idx == 8'(BASE + 8'h02)) begin
          reload_q[g] <= wbyte_q;
        end
        if (wr_idx == 8'(BASE + 8'h03)) begin
          duty_q[g] <= wbyte_q;
        end
      end
    end

    pwm_channel u_ch (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .tick       (tick),
      .run        (run_eff[g]),
      .mode       (mode),
      .psc        (psc),
      .low_reload (reload_q[g]),
      .duty       (duty_q[g]),
      .wr_low     (wr_low[g]),
      .wr_high    (wr_high[g]),
      .wdata      (wbyte_q),
      .low_q      (low_cnt[g]),
      .high_q     (high_cnt[g]),
      .wave_q     (wave[g]),
      .ovf_q      (ovf[g])
    );

    // Pin is released when the enable drops; input role is handled elsewhere
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        pin_o_q[g]   <= 1'b0;
        pin_oe_q[g]  <= 1'b0;
        ovf_out_q[g] <= 1'b0;
      end else begin
        pin_o_q[g]   <= en[g] && wave[g];
        pin_oe_q[g]  <= en[g];
        ovf_out_q[g] <= ovf[g];
      end
    end

    AST_PIN_RELEASE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !en[g] |=> !pin_oe_q[g] && !pin_o_q[g])
      else $error("Pin still driven with wave disabled");
    AST_PIN_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!reset_n)
      en[g] |=> pin_oe_q[g] && pin_o_q[g] == $past(wave[g]))
      else $error("Pin does not follow the waveform");
    AST_GATE_HALT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (gate_bit && !gate_sync_q[g] && !wr_low[g] && !wr_high[g])
        |=> $stable(low_cnt[g]) && $stable(high_cnt[g]))
      else $error("Counter moved while gated off");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ovf[g] |=> flag_q[g] && ovf_out_q[g])
      else $error("Overflow flag not raised");
  end

  // ==========================================================================
  // Bus checks
  sequence seq_aw_w_taken;
    (wr_state_q == pwm_pkg::WR_IDLE) ##0 (aw_held_q && w_held_q);
  endsequence

  AST_WRITE_ANSWER: assert property (@(posedge clk_sys) disable iff (!reset_n)
    seq_aw_w_taken |=> bvalid_q ##0 (bresp_q == (addr_hit($past(aw_addr_q)) ?
                                     `RESP_OKAY : `RESP_SLVERR)))
    else $error("Write response missing or wrong");
  AST_READ_ANSWER: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (arvalid && arready_q) |=> rvalid_q && !arready_q)
    else $error("Read data not returned in one cycle");

endmodule : timer_pwm_output_unit
